// [core/qco_map.svh]
`ifndef QCO_MAP_SVH
`define QCO_MAP_SVH

// register indices; byte address is four times the index
`define QCO_IDX_STAT      10'h00c
`define QCO_IDX_ANGLE     10'h014
`define QCO_IDX_CFG       10'h025
`define QCO_IDX_CTRL      10'h026

// configuration word fields
`define QCO_CFG_INV       1
`define QCO_CFG_RES       5:2
`define QCO_CFG_SLEW      11:6
`define QCO_CFG_IDXM      13:12
`define QCO_CFG_HYST      22:20

// control word fields
`define QCO_CTL_POLES     3:0
`define QCO_CTL_CHSEL     4
`define QCO_CTL_DIRP      5
`define QCO_CTL_DIRS      6
`define QCO_CTL_HYSTEN    7

// status word fields
`define QCO_STA_HEAD      1
`define QCO_STA_SLEW      4
`define QCO_ANGLE_FLD     15:0

// reset values
`define QCO_CFG_RST       32'h0000_0008
`define QCO_CTRL_RST      32'h0000_0000

// slew timing: time = (setting + 1) * step, rounded up to clocks
`define QCO_SLEW_STEP_PS  32'h0001_e848
`define QCO_CLK_PS        32'h0000_1f40

// axi responses
`define QCO_RESP_OKAY     2'h0

`endif

// [core/qco_pkg.sv]
`default_nettype none
package qco_pkg;
	// write channel states, one-hot
	typedef enum logic [1:0] {
		QCO_WR_IDLE = 2'b01,
		QCO_WR_RESP = 2'b10
	} qco_wr_state_t;
	typedef logic [15:0] qco_angle_t;
endpackage
`default_nettype wire

// [core/qco_top.sv]
// Behaviour
// - increasing angle: index rises at zero
// - decreasing angle: index falls at zero
// - index width from resolution and mode
// - slew limiting only for nonzero setting
// - hold each quadrature state slew time
// - slew time 0.25us plus 0.125us steps
// - skipped states walked through at slew rate
// - slew limited flag in status bit
// - unlimited: outputs follow every sample
// - reversal back-fills hysteresis edges, slew rate
// - commutation for 1 to 16 pole pairs
// - commutation toggles at transition angles
// - hysteresis window is 2^(H+1) steps
// - outputs use compensated angle, readable
// - same direction: compensated equals channel angle
// - reversal freezes angle; far exit flips head
// - head direction readable in status
// - zero slew: no catch-up, direct output
// - four index widths from two-bit field
// - inversion bit inverts quadrature and commutation
// - nonzero slew: catch up after reset
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "qco_map.svh"
`default_nettype none

module qco_top
	import qco_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire qco_angle_t  angle_primary,
	input  wire qco_angle_t  angle_secondary,
	input  wire logic        angle_strobe,
	output logic             quad_a,
	output logic             quad_b,
	output logic             quad_index,
	output logic             comm_u,
	output logic             comm_v,
	output logic             comm_w
);

	////////////////////////////////////////////////////////////////////
	// register storage

	logic [31:0]   cfg_reg;        // configuration word
	logic [31:0]   ctrl_reg;       // pole pairs, channel, direction
	logic          slew_flag_reg;  // sticky slew limited flag
	logic          head_dir_reg;   // 1 = increasing reference
	qco_angle_t    head_reg;       // hysteresis window head
	qco_angle_t    comp_reg;       // compensated output angle
	logic          init_reg;       // first sample seen
	logic [15:0]   qpos_reg;       // quadrature position
	logic [9:0]    timer_reg;      // clocks since last step

	// named views of the configuration fields
	logic          inv_out;
	logic [3:0]    res_sel;
	logic [5:0]    slew_set;
	logic [1:0]    idx_mode;
	logic [2:0]    hyst_set;
	assign inv_out  = cfg_reg[`QCO_CFG_INV];
	assign res_sel  = cfg_reg[`QCO_CFG_RES];
	assign slew_set = cfg_reg[`QCO_CFG_SLEW];
	assign idx_mode = cfg_reg[`QCO_CFG_IDXM];
	assign hyst_set = cfg_reg[`QCO_CFG_HYST];

	////////////////////////////////////////////////////////////////////
	// axi4-lite write channel

	qco_wr_state_t wr_state_reg;   // write response state
	logic          aw_got_reg;     // address held
	logic          w_got_reg;      // data held
	logic [11:0]   awaddr_reg;     // captured address
	logic [31:0]   wdata_reg;      // captured data
	logic [3:0]    wstrb_reg;      // captured strobes
	logic          aw_take;        // address handshake now
	logic          w_take;         // data handshake now
	logic          wr_fire;        // write commits this cycle
	logic [11:0]   wr_addr;        // address of committing write
	logic [31:0]   wr_data;        // data of committing write
	logic [3:0]    wr_strb;        // strobes of committing write
	logic [31:0]   wr_mask;        // strobes as bit mask

	// ready only while idle and that half not yet held
	assign s_axi_awready = (wr_state_reg == QCO_WR_IDLE) && !aw_got_reg;
	assign s_axi_wready  = (wr_state_reg == QCO_WR_IDLE) && !w_got_reg;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take  = s_axi_wvalid && s_axi_wready;
	// commit once both halves are present, in either order
	assign wr_fire = (aw_got_reg || aw_take) && (w_got_reg || w_take);
	assign wr_addr = aw_got_reg ? awaddr_reg : s_axi_awaddr;
	assign wr_data = w_got_reg ? wdata_reg : s_axi_wdata;
	assign wr_strb = w_got_reg ? wstrb_reg : s_axi_wstrb;
	assign s_axi_bvalid = (wr_state_reg == QCO_WR_RESP);
	assign s_axi_bresp  = `QCO_RESP_OKAY;

	// byte lanes expand to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wr_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
		end
	endgenerate

	// write state and captured halves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= QCO_WR_IDLE;
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			awaddr_reg   <= 12'h000;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
		end else begin
			case (wr_state_reg)
				QCO_WR_IDLE: begin
					if (wr_fire) begin
						wr_state_reg <= QCO_WR_RESP;
						aw_got_reg   <= 1'b0;
						w_got_reg    <= 1'b0;
					end else begin
						// hold whichever half came first
						if (aw_take) begin
							aw_got_reg <= 1'b1;
							awaddr_reg <= s_axi_awaddr;
						end
						if (w_take) begin
							w_got_reg <= 1'b1;
							wdata_reg <= s_axi_wdata;
							wstrb_reg <= s_axi_wstrb;
						end
					end
				end
				QCO_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_reg <= QCO_WR_IDLE;
					end
				end
				default: begin
					wr_state_reg <= QCO_WR_IDLE;
				end
			endcase
		end
	end

	// writable registers; unmapped writes are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg  <= `QCO_CFG_RST;
			ctrl_reg <= `QCO_CTRL_RST;
		end else if (wr_fire) begin
			if (wr_addr == {`QCO_IDX_CFG, 2'b00}) begin
				cfg_reg <= (cfg_reg & ~wr_mask) | (wr_data & wr_mask);
			end
			if (wr_addr == {`QCO_IDX_CTRL, 2'b00}) begin
				ctrl_reg <= (ctrl_reg & ~wr_mask) | (wr_data & wr_mask);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	logic [31:0]   rd_word;        // decoded read value

	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = `QCO_RESP_OKAY;

	// read decode; unmapped addresses read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			{`QCO_IDX_STAT, 2'b00}: begin
				rd_word[`QCO_STA_HEAD] = head_dir_reg;
				rd_word[`QCO_STA_SLEW] = slew_flag_reg;
			end
			{`QCO_IDX_ANGLE, 2'b00}: begin
				rd_word[`QCO_ANGLE_FLD] = comp_reg;
			end
			{`QCO_IDX_CFG, 2'b00}: begin
				rd_word = cfg_reg;
			end
			{`QCO_IDX_CTRL, 2'b00}: begin
				rd_word = ctrl_reg;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// read data register, held until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// channel angle and hysteresis

	qco_angle_t    chan_raw;       // selected channel angle
	logic          chan_dir;       // direction select of channel
	qco_angle_t    chan_ang;       // angle after direction select
	logic signed [15:0] hdiff;     // sample minus head
	logic [15:0]   hwin;           // window width in steps

	assign chan_raw = ctrl_reg[`QCO_CTL_CHSEL] ? angle_secondary
		: angle_primary;
	assign chan_dir = ctrl_reg[`QCO_CTL_CHSEL] ? ctrl_reg[`QCO_CTL_DIRS]
		: ctrl_reg[`QCO_CTL_DIRP];
	// a set direction bit turns the angle round, so it reads decreasing
	assign chan_ang = chan_dir ? 16'h0000 - chan_raw : chan_raw;
	assign hdiff    = $signed(chan_ang - head_reg);
	// widen before adding one so that setting 7 does not wrap to zero
	assign hwin     = 16'h0001 << ({1'b0, hyst_set} + 4'h1);

	// hysteresis head, direction and compensated angle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_reg     <= 1'b0;
			head_dir_reg <= 1'b1;
			head_reg     <= 16'h0000;
			comp_reg     <= 16'h0000;
		end else if (angle_strobe) begin
			if (!init_reg || !ctrl_reg[`QCO_CTL_HYSTEN]) begin
				// first sample fixes head, increasing reference
				init_reg     <= 1'b1;
				head_dir_reg <= init_reg ? head_dir_reg : 1'b1;
				head_reg     <= chan_ang;
				comp_reg     <= chan_ang;
			end else if (head_dir_reg ? hdiff >= 16'sh0000
				: hdiff <= 16'sh0000) begin
				// moving on with the head: no added latency
				head_reg <= chan_ang;
				comp_reg <= chan_ang;
			end else if (head_dir_reg ? hdiff < -$signed(hwin)
				: hdiff > $signed(hwin)) begin
				// left at the far side: head flips there
				head_dir_reg <= !head_dir_reg;
				head_reg     <= chan_ang;
				comp_reg     <= chan_ang;
			end
			// inside the window the compensated angle stays frozen
		end
	end

	////////////////////////////////////////////////////////////////////
	// quadrature position and slew limiting

	logic [15:0]   qmask;          // position modulus mask
	logic [15:0]   qtarget;        // position of compensated angle
	logic [15:0]   qdist;          // forward distance to target
	logic          qfwd;           // shortest way is forward
	logic          slew_on;        // limiting enabled
	logic [31:0]   slew_prod;      // slew time in picoseconds
	logic [31:0]   slew_cyc32;     // slew time in clocks
	logic [9:0]    slew_cyc;       // slew time in clocks, sized
	logic          slew_ok;        // slew time has elapsed
	logic          q_step;         // position moves this cycle
	logic          q_limited;      // limiting holds output back

	// resolution step r gives 2^(16-r) positions per turn
	assign qmask   = 16'hffff >> res_sel;
	assign qtarget = comp_reg >> res_sel;
	assign qdist   = (qtarget - qpos_reg) & qmask;
	assign qfwd    = qdist <= (qmask >> 1);
	assign slew_on = slew_set != 6'h00;
	// setting n lasts (n+1) eighths of a microsecond, rounded up
	assign slew_prod  = ({26'h0, slew_set} + 32'h1) * `QCO_SLEW_STEP_PS;
	assign slew_cyc32 = (slew_prod + `QCO_CLK_PS - 32'h1) / `QCO_CLK_PS;
	assign slew_cyc   = slew_cyc32[9:0];
	assign slew_ok    = timer_reg >= slew_cyc;
	assign q_step     = (qdist != 16'h0000) && slew_ok;
	// limited when a state is skipped or a step must wait
	assign q_limited  = slew_on && (qdist != 16'h0000)
		&& (!slew_ok || (qdist != 16'h0001 && qdist != qmask));

	// quadrature position; one step per slew expiry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qpos_reg <= 16'h0000;
		end else if (!slew_on) begin
			// unlimited: jump straight to each sample
			qpos_reg <= qtarget;
		end else if (q_step) begin
			// walk every state in between, either way round
			qpos_reg <= (qfwd ? qpos_reg + 16'h0001
				: qpos_reg - 16'h0001) & qmask;
		end
	end

	// slew timer; restarts on each quadrature step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_reg <= 10'h000;
		end else if (q_step && slew_on) begin
			timer_reg <= 10'h001;
		end else if (!slew_ok) begin
			// saturate at expiry so a late step goes at once
			timer_reg <= timer_reg + 10'h001;
		end
	end

	// sticky flag; an event in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slew_flag_reg <= 1'b0;
		end else if (q_limited) begin
			slew_flag_reg <= 1'b1;
		end else if (wr_fire && wr_addr == {`QCO_IDX_STAT, 2'b00}
			&& wr_mask[`QCO_STA_SLEW] && wr_data[`QCO_STA_SLEW]) begin
			slew_flag_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// quadrature and index outputs

	logic [15:0]   idx_width;      // index length in positions
	logic          idx_level;      // index before inversion

	// index high over the first positions after zero: rising edge
	// at zero going up, falling edge at zero going down
	assign idx_width = 16'h0001 << idx_mode;
	assign idx_level = qpos_reg < idx_width;

	// registered quadrature lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			quad_a     <= 1'b0;
			quad_b     <= 1'b0;
			quad_index <= 1'b0;
		end else begin
			quad_a     <= (qpos_reg[0] ^ qpos_reg[1]) ^ inv_out;
			quad_b     <= qpos_reg[1] ^ inv_out;
			quad_index <= idx_level ^ inv_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// commutation outputs

	logic [20:0]   elec_prod;      // angle times pole pairs
	logic [15:0]   elec_ang;       // electrical angle
	logic [18:0]   sect_prod;      // electrical angle times six
	logic [2:0]    sector;         // sixty degree sector
	logic [2:0]    uvw;            // phase pattern

	// pole pairs field holds count minus one
	assign elec_prod = comp_reg * ({1'b0, ctrl_reg[`QCO_CTL_POLES]}
		+ 5'h01);
	assign elec_ang  = elec_prod[15:0];
	assign sect_prod = {3'h0, elec_ang} * 19'h00006;
	assign sector    = sect_prod[18:16];

	// six-step pattern; follows the hysteresis angle
	always_comb begin
		case (sector)
			3'h0: uvw = 3'b100;
			3'h1: uvw = 3'b110;
			3'h2: uvw = 3'b010;
			3'h3: uvw = 3'b011;
			3'h4: uvw = 3'b001;
			3'h5: uvw = 3'b101;
			default: uvw = 3'b100;
		endcase
	end

	// registered commutation lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comm_u <= 1'b0;
			comm_v <= 1'b0;
			comm_w <= 1'b0;
		end else begin
			comm_u <= uvw[2] ^ inv_out;
			comm_v <= uvw[1] ^ inv_out;
			comm_w <= uvw[0] ^ inv_out;
		end
	end

endmodule

`default_nettype wire

// [test/qco_quad_rx.sv]
`default_nettype none
// quadrature receiver: counts steps, flags skipped states, keeps min gap
module qco_quad_rx (
	input  wire logic         aclk,
	input  wire logic         clr,
	input  wire logic         quad_a,
	input  wire logic         quad_b,
	output logic signed [15:0] count,
	output logic [15:0]       skips,
	output logic [15:0]       gap_min
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]  last_reg; // previous decoded state
	logic [15:0] cyc_reg;  // clocks since the last edge, saturating
	logic [1:0]  pos;      // decoded gray position
	logic [1:0]  dlt;      // step between samples, modulo four
	assign pos = {quad_b, quad_a ^ quad_b};
	assign dlt = pos - last_reg;
	//////////////////////////////////////////////////////////////////////
	// a jump of two states cannot be told apart from either direction,
	// so a real receiver loses count there: it is only tallied
	always_ff @(posedge aclk) begin
		last_reg <= pos;
		if (clr) begin
			count   <= '0;
			skips   <= '0;
			gap_min <= 16'hffff;
			cyc_reg <= 16'hffff;
		end else if (dlt != 2'h0) begin
			cyc_reg <= 16'h0001;
			if (cyc_reg < gap_min)
				gap_min <= cyc_reg;
			if (dlt == 2'h2)
				skips <= skips + 16'h0001;
			else
				count <= count + ((dlt == 2'h1) ? 16'sd1 : -16'sd1);
		end else if (cyc_reg != 16'hffff) begin
			cyc_reg <= cyc_reg + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// [test/qco_top_chk.sv]
`default_nettype none
module qco_top_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        angle_strobe,
	input wire logic        quad_a,
	input wire logic        quad_b,
	input wire logic        quad_index,
	input wire logic        comm_u,
	input wire logic        comm_v,
	input wire logic        comm_w
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] calm_reg; // clocks since a strobe or write answer
	logic [2:0] uvw;      // commutation pattern
	assign uvw = {comm_u, comm_v, comm_w};
	//////////////////////////////////////////////////////////////////////
	// commutation has only two causes; both restart this count
	always_ff @(posedge aclk) begin
		if (!aresetn || angle_strobe || s_axi_bvalid)
			calm_reg <= 3'h0;
		else if (calm_reg != 3'h7)
			calm_reg <= calm_reg + 3'h1;
	end
	a_reset_idle: assert property (!$past(aresetn) |->
		!quad_a && !quad_b && !quad_index && uvw == 3'h0 &&
		s_axi_arready && !s_axi_rvalid && !s_axi_bvalid)
		else $error("outputs not idle after reset");
	a_uvw_legal: assert property ($past(angle_strobe, 3) |->
		uvw != 3'h0 && uvw != 3'h7)
		else $error("commutation pattern illegal");
	a_comm_quiet: assert property (calm_reg == 3'h7 |->
		$stable(uvw))
		else $error("commutation moved without cause");
	a_rd_excl: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid)
		else $error("read answer not released");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && s_axi_rresp == 2'h0)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> s_axi_bvalid ##0
		s_axi_bresp == 2'h0)
		else $error("write answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid)
		else $error("write answer dropped");
endmodule
bind qco_top qco_top_chk chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.angle_strobe, .quad_a, .quad_b, .quad_index, .comm_u, .comm_v,
	.comm_w);
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
module testbench
	import qco_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] STA = 12'h030, ANG = 12'h050;
	localparam logic [11:0] CFG = 12'h094, CTL = 12'h098;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, angle_strobe;
	logic quad_a, quad_b, quad_index, comm_u, comm_v, comm_w, rx_clr;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	qco_angle_t  angle_primary, angle_secondary;
	logic signed [15:0] rx_count;
	logic [15:0] rx_skips, rx_gap;
	int          fail_count, n_tests, cyc;
	qco_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .angle_primary,
		.angle_secondary, .angle_strobe, .quad_a, .quad_b, .quad_index,
		.comm_u, .comm_v, .comm_w);
	qco_quad_rx rx (.aclk, .clr(rx_clr), .quad_a, .quad_b,
		.count(rx_count), .skips(rx_skips), .gap_min(rx_gap));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// generous ceiling: the slowest slew case needs a few thousand clocks
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fail_count++;
			print_verdict;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// halves are released on their own handshakes; readies seen at negedge
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !aw_ok) || (s_axi_wvalid && !w_ok));
		do @(negedge aclk); while (!s_axi_bvalid);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	// one sample; returns at a negedge once the pins have settled
	task automatic feed(input logic [15:0] a);
		@(posedge aclk);
		angle_primary <= a;
		angle_secondary <= a ^ 16'h8000;
		angle_strobe <= 1'b1;
		@(posedge aclk);
		angle_strobe <= 1'b0;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic clr_rx;
		@(posedge aclk);
		rx_clr <= 1'b1;
		@(posedge aclk);
		rx_clr <= 1'b0;
	endtask
	function automatic logic [31:0] cfgw(int h, m, s, r, i);
		return 32'(h << 20 | m << 12 | s << 6 | r << 2 | i << 1);
	endfunction
	function automatic logic [31:0] ctlw(int pp, ch, dp, he);
		return 32'((pp - 1) | ch << 4 | dp << 5 | he << 7);
	endfunction
	function automatic logic [1:0] qexp(logic [15:0] c, int r);
		logic [15:0] p;
		p = c >> r;
		return {p[0] ^ p[1], p[1]};
	endfunction
	function automatic logic [2:0] uexp(logic [15:0] c, int pp);
		logic [15:0] e;
		e = 16'(c * pp);
		case ((32'(e) * 6) >> 16)
			0: return 3'h4;
			1: return 3'h6;
			2: return 3'h2;
			3: return 3'h3;
			4: return 3'h1;
			default: return 3'h5;
		endcase
	endfunction
	//////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		axi_rd(CFG, rd);
		chk("config reset", 32'h8, rd);
		axi_rd(STA, rd);
		chk("status reset", 32'h2, rd);
		axi_wr(12'hffc, 32'hffff_ffff);
		axi_rd(12'hffc, rd);
		chk("unmapped", 32'h0, rd);
	endtask
	task automatic t_direct;
		for (int p = 0; p < 5; p++) begin
			feed(16'(p * 4));
			chk("quad", qexp(16'(p * 4), 2), {quad_a, quad_b});
		end
		axi_rd(ANG, rd);
		chk("angle", 32'h10, rd);
		clr_rx;
		feed(16'h0018);
		chk("direct jump", 1, rx_skips);
		axi_rd(STA, rd);
		chk("no limiting", 0, rd[4]);
	endtask
	// index must span exactly 2^mode positions, either direction
	task automatic t_index;
		int ka;
		for (int r = 2; r < 6; r += 3)
			for (int m = 0; m < 4; m++) begin
				axi_wr(CFG, cfgw(0, m, 0, r, 0));
				for (int d = 0; d < 2; d++)
					for (int k = -2; k < (1 << m) + 2; k++) begin
						ka = d ? (1 << m) - 1 - k : k;
						feed(16'(ka << r));
						chk("index", ka >= 0 && ka < (1 << m), quad_index);
					end
			end
		axi_wr(CTL, ctlw(1, 0, 1, 0));
		feed(16'h0010);
		axi_rd(ANG, rd);
		chk("negated angle", 32'hfff0, rd);
		axi_wr(CTL, ctlw(1, 0, 0, 0));
	endtask
	task automatic t_slew(input int n);
		int nclk;
		nclk = ((n + 1) * 125 + 7) / 8;
		axi_wr(CFG, cfgw(0, 0, 0, 2, 0));
		feed(16'h0000);
		axi_wr(STA, 32'h10);
		axi_wr(CFG, cfgw(0, 0, n, 2, 0));
		clr_rx;
		feed(16'h000c);
		repeat (4 * nclk) @(posedge aclk);
		chk("steps", 32'h3, 32'(rx_count));
		chk("skips", 32'h0, rx_skips);
		chk("gap", 1, rx_gap >= nclk && rx_gap <= nclk + 1);
		axi_rd(STA, rd);
		chk("slew flag", 1, rd[4]);
		axi_wr(STA, 32'h10);
		axi_rd(STA, rd);
		chk("flag cleared", 0, rd[4]);
	endtask
	task automatic t_hyst;
		logic [15:0] w;
		axi_wr(CTL, ctlw(1, 0, 0, 1));
		for (int h = 0; h < 8; h++) begin
			w = 16'(2 << h);
			axi_wr(CFG, cfgw(h, 0, 1, 12, 0));
			feed(16'h3000);
			feed(16'h4000);
			feed(16'h4001);
			axi_rd(ANG, rd);
			chk("tracking", 32'h4001, rd);
			feed(16'h4001 - w);
			axi_rd(ANG, rd);
			chk("frozen", 32'h4001, rd);
			axi_rd(STA, rd);
			chk("head up", 1, rd[1]);
			// let the slew-limited walk settle before counting edges
			repeat (300) @(posedge aclk);
			clr_rx;
			feed(16'h4000 - w);
			axi_rd(ANG, rd);
			chk("flipped", 32'(16'h4000 - w), rd);
			axi_rd(STA, rd);
			chk("head down", 0, rd[1]);
			repeat (40) @(posedge aclk);
			chk("back-fill", -1, 32'(rx_count));
		end
		axi_wr(CTL, ctlw(1, 0, 0, 0));
		axi_wr(CFG, cfgw(0, 0, 0, 2, 0));
	endtask
	task automatic t_comm;
		for (int pp = 1; pp <= 16; pp++) begin
			axi_wr(CTL, ctlw(pp, 0, 0, 0));
			feed(16'h1234);
			chk("uvw", uexp(16'h1234, pp), {comm_u, comm_v, comm_w});
		end
		axi_wr(CTL, ctlw(1, 1, 0, 0));
		feed(16'h1234);
		chk("uvw second", uexp(16'h9234, 1), {comm_u, comm_v, comm_w});
		axi_wr(CTL, ctlw(1, 0, 0, 0));
		axi_wr(CFG, cfgw(0, 0, 0, 2, 1));
		feed(16'h0004);
		chk("inverted", {~qexp(16'h4, 2), 1'b1, ~uexp(16'h4, 1)},
			{quad_a, quad_b, quad_index, comm_u, comm_v, comm_w});
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, angle_strobe, rx_clr} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{angle_primary, angle_secondary} = '0;
		s_axi_wstrb = 4'hf;
		{fail_count, n_tests, cyc} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_direct;
		t_index;
		t_slew(1);
		t_slew(63);
		t_hyst;
		t_comm;
		print_verdict;
	end
endmodule
`default_nettype wire
